// >>> hw/rpp_regs.vh
// register offsets, pin masks, reset values and constants for the reduced-pin port block
// assumes a 32-bit classic wishbone slave with byte addresses on adr[7:0]
`ifndef RPP_REGS_VH
`define RPP_REGS_VH

// word offsets, compared against adr[7:2]
`define RPP_OFF_P0_IN 6'h00
`define RPP_OFF_PORT_FIRST 6'h01
`define RPP_OFF_PORT_LAST 6'h10
`define RPP_OFF_ADC_CTRL 6'h11
`define RPP_OFF_ADC_RESULT 6'h12
`define RPP_OFF_EP_TIMER 6'h13
`define RPP_OFF_EP_CMP_FIRST 6'h14
`define RPP_OFF_EP_CMP_LAST 6'h17
`define RPP_OFF_EP_STATUS 6'h18

// sub-register order inside one port group
`define RPP_SUB_INPUT 2'h0
`define RPP_SUB_LATCH 2'h1
`define RPP_SUB_DIR 2'h2
`define RPP_SUB_MODE 2'h3

// bits that still have logic behind them
`define RPP_P0_TIE_MASK 8'hFC
`define RPP_P1_IMPL 8'h0F
`define RPP_P2_IMPL 8'hD7
`define RPP_P5_IMPL 8'h0D
`define RPP_P6_IMPL 8'hF3

// fixed read value of removed input, latch and direction bits
`define RPP_P1_FIX 8'hF0
`define RPP_P2_FIX 8'h28
`define RPP_P5_FIX 8'h00
`define RPP_P6_FIX 8'h0C
`define RPP_MODE_FIX 8'h00

// reset values of implemented bits
`define RPP_RST_LATCH 8'h00
`define RPP_RST_DIR 8'hFF
`define RPP_RST_MODE 8'h00

// field positions
`define RPP_ADC_CHAN_MSB 2
`define RPP_ADC_START_BIT 3
`define RPP_ADC_DONE_BIT 16
`define RPP_CMP_CONV_BIT 16
`define RPP_CMP_RSTT_BIT 17
`define RPP_HOLD_ACK_BIT 6

`define RPP_ADC_FULL_SCALE 10'h3FF
`define RPP_ADC_TIED_CHANS 3'h2

`endif

// >>> hw/rpp_port_stubs.v
// port registers of a reduced-pin controller, with removed pins stubbed out,
// a converter channel front end and four internal compare channels
// assumes synchronous pin inputs and a classic wishbone master on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "rpp_regs.vh"

module rpp_port_stubs (
	input wire clk_i,
	input wire rst_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [7:0] port0_pin_i,
	input wire [7:0] port1_pin_i,
	input wire [7:0] port2_pin_i,
	input wire [7:0] port5_pin_i,
	input wire [7:0] port6_pin_i,
	output wire [7:0] port1_out_o,
	output wire [7:0] port1_oe_o,
	output wire [7:0] port2_out_o,
	output wire [7:0] port2_oe_o,
	output wire [7:0] port5_out_o,
	output wire [7:0] port5_oe_o,
	output wire [7:0] port6_out_o,
	output wire [7:0] port6_oe_o,
	input wire [9:0] adc_sample_i,
	output reg [2:0] adc_channel_o,
	output reg on_circuit_emulation_mode_o
);

	localparam [31:0] IMPL = {`RPP_P6_IMPL, `RPP_P5_IMPL, `RPP_P2_IMPL, `RPP_P1_IMPL};
	localparam [31:0] FIX = {`RPP_P6_FIX, `RPP_P5_FIX, `RPP_P2_FIX, `RPP_P1_FIX};

	wire [31:0] pin_all;
	assign pin_all = {port6_pin_i, port5_pin_i, port2_pin_i, port1_pin_i};

	// bus decode
	wire req;
	wire wr;
	wire [5:0] idx;
	wire [5:0] pidx;
	wire in_ports;
	wire [1:0] port_sel;
	wire [1:0] sub_sel;
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i;
	assign idx = wb_adr_i[7:2];
	assign pidx = idx - `RPP_OFF_PORT_FIRST;
	assign in_ports = (idx >= `RPP_OFF_PORT_FIRST) && (idx <= `RPP_OFF_PORT_LAST);
	assign port_sel = pidx[3:2];
	assign sub_sel = pidx[1:0];

	// port registers, one group each for ports 1, 2, 5 and 6
	reg [7:0] latch_reg [0:3];
	reg [7:0] dir_reg [0:3];
	reg [7:0] mode_reg [0:3];
	reg [7:0] out_reg [0:3];
	reg [7:0] oe_reg [0:3];
	wire [127:0] port_rd;

	genvar k;
	generate
		for (k = 0; k < 4; k = k + 1) begin : g_port
			wire [7:0] impl;
			wire [7:0] fix;
			wire hit;
			assign impl = IMPL[k*8 +: 8];
			assign fix = FIX[k*8 +: 8];
			assign hit = wr && in_ports && (port_sel == k) && wb_sel_i[0];

			always @(posedge clk_i) begin
				if (rst_i) begin
					latch_reg[k] <= `RPP_RST_LATCH & impl;
					dir_reg[k] <= `RPP_RST_DIR & impl;
					mode_reg[k] <= `RPP_RST_MODE & impl;
					out_reg[k] <= 8'h00;
					oe_reg[k] <= 8'h00;
				end else begin
					// only bits with logic behind them store anything
					if (hit && sub_sel == `RPP_SUB_LATCH) begin
						latch_reg[k] <= wb_dat_i[7:0] & impl;
					end
					if (hit && sub_sel == `RPP_SUB_DIR) begin
						dir_reg[k] <= wb_dat_i[7:0] & impl;
					end
					if (hit && sub_sel == `RPP_SUB_MODE) begin
						mode_reg[k] <= wb_dat_i[7:0] & impl;
					end
					// a pin is driven in port mode with direction cleared; removed pins never drive
					out_reg[k] <= latch_reg[k] & ~mode_reg[k] & impl;
					oe_reg[k] <= ~dir_reg[k] & ~mode_reg[k] & impl;
				end
			end

			// hardwired values merged over the missing bits
			assign port_rd[k*32 + 0 +: 8] = (pin_all[k*8 +: 8] & impl) | (fix & ~impl);
			assign port_rd[k*32 + 8 +: 8] = (latch_reg[k] & impl) | (fix & ~impl);
			assign port_rd[k*32 + 16 +: 8] = (dir_reg[k] & impl) | (fix & ~impl);
			assign port_rd[k*32 + 24 +: 8] = (mode_reg[k] & impl) | (`RPP_MODE_FIX & ~impl);
		end
	endgenerate

	assign port1_out_o = out_reg[0];
	assign port1_oe_o = oe_reg[0];
	assign port2_out_o = out_reg[1];
	assign port2_oe_o = oe_reg[1];
	assign port5_out_o = out_reg[2];
	assign port5_oe_o = oe_reg[2];
	assign port6_out_o = out_reg[3];
	assign port6_oe_o = oe_reg[3];

	// emulation strap, caught in the first cycle after reset releases
	reg in_reset_reg;
	always @(posedge clk_i) begin
		if (rst_i) begin
			in_reset_reg <= 1'b1;
			on_circuit_emulation_mode_o <= 1'b0;
		end else begin
			in_reset_reg <= 1'b0;
			if (in_reset_reg) begin
				on_circuit_emulation_mode_o <= ~port2_pin_i[`RPP_HOLD_ACK_BIT];
			end
		end
	end

	// compare channels 4-7 on a free-running timer, no pins
	reg [15:0] timer_reg;
	reg [15:0] cmp_reg [0:3];
	reg [3:0] conv_en_reg;
	reg [3:0] rstt_en_reg;
	reg [3:0] match_reg;
	wire [15:0] timer_inc;
	wire [3:0] match_now;
	wire [3:0] match_clr;
	assign timer_inc = timer_reg + 16'h0001;

	generate
		for (k = 0; k < 4; k = k + 1) begin : g_cmp
			wire hit;
			// a match needs the timer to count onto the value, not be loaded to it
			assign match_now[k] = (timer_inc == cmp_reg[k]);
			assign hit = wr && (idx == `RPP_OFF_EP_CMP_FIRST + k);
			always @(posedge clk_i) begin
				if (rst_i) begin
					cmp_reg[k] <= 16'hFFFF;
					conv_en_reg[k] <= 1'b0;
					rstt_en_reg[k] <= 1'b0;
				end else if (hit) begin
					if (wb_sel_i[0]) begin
						cmp_reg[k][7:0] <= wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						cmp_reg[k][15:8] <= wb_dat_i[15:8];
					end
					if (wb_sel_i[2]) begin
						conv_en_reg[k] <= wb_dat_i[`RPP_CMP_CONV_BIT];
						rstt_en_reg[k] <= wb_dat_i[`RPP_CMP_RSTT_BIT];
					end
				end
			end
		end
	endgenerate

	assign match_clr = (wr && idx == `RPP_OFF_EP_STATUS && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

	always @(posedge clk_i) begin
		if (rst_i) begin
			timer_reg <= 16'h0000;
			match_reg <= 4'h0;
		end else begin
			if (|(match_now & rstt_en_reg)) begin
				timer_reg <= 16'h0000;
			end else begin
				timer_reg <= timer_inc;
			end
			// a new match beats a clear in the same cycle
			match_reg <= (match_reg & ~match_clr) | match_now;
		end
	end

	// converter front end
	reg adc_done_reg;
	reg [9:0] adc_result_reg;
	wire ctrl_wr;
	wire [2:0] chan_eff;
	wire start;
	assign ctrl_wr = wr && (idx == `RPP_OFF_ADC_CTRL) && wb_sel_i[0];
	assign chan_eff = ctrl_wr ? wb_dat_i[`RPP_ADC_CHAN_MSB:0] : adc_channel_o;
	assign start = (ctrl_wr && wb_dat_i[`RPP_ADC_START_BIT]) || |(match_now & conv_en_reg);

	always @(posedge clk_i) begin
		if (rst_i) begin
			adc_channel_o <= 3'h0;
			adc_result_reg <= 10'h000;
			adc_done_reg <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				adc_channel_o <= wb_dat_i[`RPP_ADC_CHAN_MSB:0];
			end
			if (start) begin
				// channels tied to the reference at the multiplexer
				if (chan_eff < `RPP_ADC_TIED_CHANS) begin
					adc_result_reg <= `RPP_ADC_FULL_SCALE;
				end else begin
					adc_result_reg <= adc_sample_i;
				end
				adc_done_reg <= 1'b1;
			end else if (ctrl_wr) begin
				adc_done_reg <= 1'b0;
			end
		end
	end

	// read mux
	reg [31:0] rd_next;
	always @* begin
		rd_next = 32'h0000_0000;
		if (idx == `RPP_OFF_P0_IN) begin
			rd_next[7:0] = port0_pin_i & `RPP_P0_TIE_MASK;
		end else if (in_ports) begin
			rd_next[7:0] = port_rd[{port_sel, sub_sel, 3'b000} +: 8];
		end else if (idx == `RPP_OFF_ADC_CTRL) begin
			rd_next[`RPP_ADC_CHAN_MSB:0] = adc_channel_o;
			rd_next[`RPP_ADC_DONE_BIT] = adc_done_reg;
		end else if (idx == `RPP_OFF_ADC_RESULT) begin
			rd_next[9:0] = adc_result_reg;
		end else if (idx == `RPP_OFF_EP_TIMER) begin
			rd_next[15:0] = timer_reg;
		end else if (idx >= `RPP_OFF_EP_CMP_FIRST && idx <= `RPP_OFF_EP_CMP_LAST) begin
			rd_next[15:0] = cmp_reg[idx[1:0]];
			rd_next[`RPP_CMP_CONV_BIT] = conv_en_reg[idx[1:0]];
			rd_next[`RPP_CMP_RSTT_BIT] = rstt_en_reg[idx[1:0]];
		end else if (idx == `RPP_OFF_EP_STATUS) begin
			rd_next[3:0] = match_reg;
		end
	end

	// one wait state, ack drops the cycle after it rose
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				wb_dat_o <= rd_next;
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

endmodule // rpp_port_stubs
`default_nettype wire

// >>> tb/rpp_port_stubs_sva.sv
// bus, strap and removed-pin checks for the reduced-pin port block
// assumes binding to rpp_port_stubs with one clock and synchronous reset
`timescale 1ns/1ps
`default_nettype none
module rpp_port_stubs_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [7:0] port0_pin_i,
	input wire logic [7:0] port2_pin_i,
	input wire logic [7:0] port1_out_o,
	input wire logic [7:0] port1_oe_o,
	input wire logic [7:0] port2_out_o,
	input wire logic [7:0] port2_oe_o,
	input wire logic [7:0] port6_out_o,
	input wire logic [7:0] port6_oe_o,
	input wire logic on_circuit_emulation_mode_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
	ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	emu_strap_load_a: assert property ($fell(rst_i) |=> on_circuit_emulation_mode_o == !$past(port2_pin_i[6]))
		else $error("emulation flag not loaded from strap");
	emu_hold_a: assert property (!$fell(rst_i) |=> $stable(on_circuit_emulation_mode_o))
		else $error("emulation flag changed after reset");
	p0_tied_low_a: assert property (rd_req && wb_adr_i == 8'h00 |=> wb_dat_o[7:0] == {$past(port0_pin_i[7:2]), 2'b00})
		else $error("port 0 read wrong");
	p1_fixed_read_a: assert property (rd_req && wb_adr_i inside {8'h04, 8'h08, 8'h0C} |=> wb_dat_o[7:4] == 4'hF)
		else $error("port 1 removed bits not one");
	port1_function_select_read_a: assert property (rd_req && wb_adr_i == 8'h10 |=> wb_dat_o[7:4] == 4'h0)
		else $error("port 1 removed select bits not zero");
	removed_idle_a: assert property (((port1_out_o | port1_oe_o) & 8'hF0) == 8'h00 && ((port2_out_o | port2_oe_o) & 8'h28) == 8'h00
		&& ((port6_out_o | port6_oe_o) & 8'h0C) == 8'h00) else $error("removed pin driven");
endmodule // rpp_port_stubs_sva
bind rpp_port_stubs rpp_port_stubs_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port0_pin_i(port0_pin_i),
	.port2_pin_i(port2_pin_i), .port1_out_o(port1_out_o), .port1_oe_o(port1_oe_o), .port2_out_o(port2_out_o),
	.port2_oe_o(port2_oe_o), .port6_out_o(port6_out_o), .port6_oe_o(port6_oe_o),
	.on_circuit_emulation_mode_o(on_circuit_emulation_mode_o));
`default_nettype wire

// >>> tb/rpp_port_stubs_test.sv
// self-checking bench for rpp_port_stubs
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
`default_nettype none
module rpp_port_stubs_test;
	logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0;
	logic [7:0] adr = 0, p0 = 8'hFF, p1 = 8'hA5, p2 = 8'h00, p5 = 8'h3C, p6 = 8'h96;
	logic [31:0] wd = 0, q;
	wire logic [31:0] rdat;
	wire logic ack, emu;
	wire logic [7:0] o1, e1, o2, e2, o5, e5, o6, e6;
	wire logic [2:0] ch;
	int fail_count = 0, cmp_count = 0;
	rpp_port_stubs u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hF),
		.wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .port0_pin_i(p0),
		.port1_pin_i(p1), .port2_pin_i(p2), .port5_pin_i(p5), .port6_pin_i(p6), .port1_out_o(o1),
		.port1_oe_o(e1), .port2_out_o(o2), .port2_oe_o(e2), .port5_out_o(o5), .port5_oe_o(e5),
		.port6_out_o(o6), .port6_oe_o(e6), .adc_sample_i(10'h155), .adc_channel_o(ch),
		.on_circuit_emulation_mode_o(emu));
	initial forever #2 clk_i = ~clk_i;
	task automatic give_verdict();
		if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 16);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 16) begin
			chk({31'h0, ack}, 32'h0000_0001);
			give_verdict();
		end
		@(posedge clk_i);
	endtask
	task automatic do_reset(input logic strap);
		rst_i <= 1'b1;
		p2[6] <= strap;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({31'h0, emu}, {31'h0, ~strap});
	endtask
	task automatic t_misc();
		xfer(8'h00, 32'h0000_0000, 1'b0);
		chk(q, 32'h0000_00FC);
		xfer(8'hFC, 32'hFFFF_FFFF, 1'b1);
		xfer(8'hFC, 32'h0000_0000, 1'b0);
		chk(q, 32'h0000_0000);
	endtask
	task automatic t_fixed();
		logic [7:0] base [4] = '{8'h04, 8'h14, 8'h24, 8'h34};
		logic [7:0] imp [4] = '{8'h0F, 8'hD7, 8'h0D, 8'hF3};
		logic [7:0] fx [4] = '{8'hF0, 8'h28, 8'h00, 8'h0C};
		logic [7:0] pin [4] = '{p1, p2, p5, p6};
		logic [7:0] w, e;
		for (int p = 0; p < 4; p++) begin
			for (int s = 0; s < 8; s++) begin
				w = s[0] ? 8'hFF : 8'h00;
				xfer(base[p] + 8'(4 * (s >> 1)), {24'h00_0000, w}, 1'b1);
				xfer(base[p] + 8'(4 * (s >> 1)), 32'h0000_0000, 1'b0);
				e = (s < 2) ? pin[p] & imp[p] : w & imp[p];
				if (s < 6) e = e | fx[p];
				chk(q, {24'h00_0000, e});
			end
		end
	endtask
	task automatic t_drive();
		xfer(8'h0C, 32'h0000_0000, 1'b1);
		xfer(8'h10, 32'h0000_0000, 1'b1);
		xfer(8'h3C, 32'h0000_0000, 1'b1);
		xfer(8'h40, 32'h0000_0000, 1'b1);
		xfer(8'h1C, 32'h0000_0000, 1'b1);
		xfer(8'h20, 32'h0000_0000, 1'b1);
		xfer(8'h2C, 32'h0000_0000, 1'b1);
		xfer(8'h30, 32'h0000_0000, 1'b1);
		@(posedge clk_i);
		chk({o1, e1, o6, e6}, 32'h0F0F_F3F3);
		chk({o2, e2, o5, e5}, 32'hD7D7_0D0D);
	endtask
	task automatic t_adc();
		for (int c = 0; c < 3; c++) begin
			xfer(8'h44, 32'(8 + c), 1'b1);
			xfer(8'h48, 32'h0000_0000, 1'b0);
			chk(q, (c < 2) ? 32'h0000_03FF : 32'h0000_0155);
			chk({29'h0000_0000, ch}, 32'(c));
		end
	endtask
	task automatic t_cmp();
		xfer(8'h44, 32'h0000_0002, 1'b1);
		xfer(8'h4C, 32'h0000_0000, 1'b0);
		xfer(8'h50, {15'h0000, 1'b1, q[15:0] + 16'h0028}, 1'b1);
		repeat (60) @(posedge clk_i);
		xfer(8'h60, 32'h0000_0000, 1'b0);
		chk(q & 32'h0000_0001, 32'h0000_0001);
		xfer(8'h44, 32'h0000_0000, 1'b0);
		chk(q & 32'h0001_0000, 32'h0001_0000);
		// write one to clear; the next match is a full timer wrap away
		xfer(8'h60, 32'h0000_0001, 1'b1);
		xfer(8'h60, 32'h0000_0000, 1'b0);
		chk(q & 32'h0000_0001, 32'h0000_0000);
		// channel 5 resets the timer shortly after this read
		xfer(8'h4C, 32'h0000_0000, 1'b0);
		xfer(8'h54, {14'h0000, 2'b10, q[15:0] + 16'h0020}, 1'b1);
		repeat (40) @(posedge clk_i);
		xfer(8'h4C, 32'h0000_0000, 1'b0);
		chk({31'h0000_0000, q[15:0] < 16'h0040}, 32'h0000_0001);
	endtask
	initial begin
		do_reset(1'b0);
		t_misc();
		t_fixed();
		t_drive();
		t_adc();
		t_cmp();
		do_reset(1'b1);
		give_verdict();
	end
endmodule // rpp_port_stubs_test
`default_nettype wire
